// >>> rtl/sbtc_pkg.sv
// Shared constants, field layouts and types of the 16-bit timer/counter.
// Assumes a single 25 MHz core clock that stands for the oscillator clock.
package sbtc_pkg;

    // Register port geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets (word index on the plain register port)
    localparam logic [2:0] OFS_CTRL     = 3'h0;
    localparam logic [2:0] OFS_CNT_LOW  = 3'h1;
    localparam logic [2:0] OFS_CNT_HIGH = 3'h2;
    localparam logic [2:0] OFS_FLAGS    = 3'h3;

    // Values after reset
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic       FLAG_RESET  = 1'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Bit positions in the flags register
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_IE_BIT  = 1;

    // Count range
    localparam int         CNT_W     = 16;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // Instruction clock is the core clock divided by four
    localparam int QCLK_DIV      = 4;
    localparam int QCLK_HALF_CYC = QCLK_DIV / 2;

    // Stage counts and prescaler width
    localparam int PIN_STAGES  = 3;
    localparam int SYNC_STAGES = 2;
    localparam int PRESC_W     = 4;

    // Control register layout, bit 7 first
    typedef struct packed {
        logic [1:0] unused;      // Always zero
        logic [1:0] prescale;    // prescale_select
        logic       osc_en;      // osc_enable
        logic       sync_bypass; // sync_bypass
        logic       clk_sel;     // clock_source_select
        logic       run;         // run_enable
    } sbtc_ctrl_t;

    // Operating modes
    typedef enum logic [1:0] {
        SBTC_TIMER,
        SBTC_SYNC_CNT,
        SBTC_ASYNC_CNT
    } sbtc_mode_t;

    // Mode decoding from the control fields
    function automatic sbtc_mode_t sbtc_mode(input sbtc_ctrl_t c);
        if (!c.clk_sel) begin
            sbtc_mode = SBTC_TIMER;
        end else if (c.sync_bypass) begin
            sbtc_mode = SBTC_ASYNC_CNT;
        end else begin
            sbtc_mode = SBTC_SYNC_CNT;
        end
    endfunction : sbtc_mode

endpackage : sbtc_pkg

// >>> rtl/sbtc_prescaler.sv
// Edge-counting prescaler, 1:1 to 1:8, symmetric output level.
// Assumes i_tick pulses once per edge (rising and falling) of the source.
`timescale 1ns/100ps
module sbtc_prescaler #(
    parameter int W = sbtc_pkg::PRESC_W
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_clear,
    input  wire logic       i_tick,
    input  wire logic [1:0] i_sel,
    output logic            o_level
);
    logic [W-1:0] cnt_q; // Edge count
    logic [W-1:0] cnt_d; // Next edge count

    // Count source edges; bit n is the source divided by 2**n
    always_comb begin
        cnt_d = cnt_q;
        if (i_clear) begin
            cnt_d = '0;
        end else if (i_tick) begin
            cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // Register the count
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Bit 0 follows the source itself, so 1:1 passes it straight on
    assign o_level = cnt_q[i_sel];

endmodule : sbtc_prescaler

// >>> rtl/sbtc_edge_sync.sv
// Sampling stages behind the prescaler and rising-edge strobe.
// Assumes i_level is in the core clock domain already.
`timescale 1ns/100ps
module sbtc_edge_sync #(
    parameter int STAGES = sbtc_pkg::SYNC_STAGES
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_level,
    input  wire logic i_bypass,
    input  wire logic i_enable,
    output logic      o_strobe
);
    logic [STAGES-1:0] stg_q; // Sampling chain
    logic [STAGES-1:0] stg_d;
    logic              prev_q; // Last seen level
    logic              prev_d;
    logic              cur;    // Level under test

    // Chain shifts only while enabled; off in sleep freezes it
    always_comb begin
        stg_d = stg_q;
        if (i_enable) begin
            stg_d = {stg_q[STAGES-2:0], i_level};
        end
        cur    = i_bypass ? i_level : stg_q[STAGES-1];
        prev_d = cur;
        // Rising edge gives one strobe of one cycle
        o_strobe = cur & ~prev_q;
    end

    // Register chain and edge memory
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stg_q  <= '0;
            prev_q <= 1'b0;
        end else begin
            stg_q  <= stg_d;
            prev_q <= prev_d;
        end
    end

endmodule : sbtc_edge_sync

// >>> rtl/sbtc_top.sv
// Top of the 16-bit timer/counter: registers, source select, count.
// Assumes one core clock; pins are asynchronous and filtered here.
//
// Behaviour
// [RULE1] 16-bit count of two bytes, wraps to zero
// [RULE2] Wrap sets sticky overflow flag
// [RULE3] Interrupt forwarded only while enable set
// [RULE4] Source select: instruction clock or external edges
// [RULE5] Run enable advances, else holds count
// [RULE6] Prescale field divides by 1,2,4,8
// [RULE7] Oscillator enable forces both pins input
// [RULE8] Bypass bit skips sync; ignored for internal
// [RULE9] Counter pin: oscillator pin or count pin
// [RULE10] Prescaler before sync, driven by input
// [RULE11] Synced counter holds in sleep, prescaler runs
// [RULE12] Source keeps high and low two periods
// [RULE13] Source period four periods over prescale
// [RULE14] Synced increments lag by sync latency
// [RULE15] Bypass counts in sleep, can wake
// [RULE16] No capture/compare time base when unsynced
// [RULE17] Count reads always return clean values
// [RULE18] Software stops counter before async writes
// [RULE19] Read high, low, high; repeat on mismatch
// [RULE20] Load: clear low, write high, write low
// [RULE21] Capture/compare trigger clears the count
// [RULE22] Control bits 7:6 read zero
// [RULE23] Count byte write clears the prescaler
// [RULE24] Trigger clear does not set flag
// [RULE25] Write beats a trigger clear
// [RULE26] Count not reset; control resets zero
// [RULE27] Flag sticks until written zero
// [RULE28] Two sampling stages, one-cycle increment strobe
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module sbtc_top (
    input  wire logic                       I_MCLK,
    input  wire logic                       I_RESET,
    input  wire logic [sbtc_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic [sbtc_pkg::DATA_W-1:0] I_WDATA,
    input  wire logic                       I_WR,
    input  wire logic                       I_RD,
    output logic      [sbtc_pkg::DATA_W-1:0] O_RDATA,
    input  wire logic                       I_SLEEP,
    input  wire logic                       I_CCP_CLEAR,
    input  wire logic                       I_OSC_IN_PIN,
    input  wire logic                       I_EXT_COUNT_PIN,
    input  wire logic [1:0]                 I_PIN_DIR_OUT,
    input  wire logic [1:0]                 I_PIN_DATA,
    output logic      [1:0]                 O_PIN_O,
    output logic      [1:0]                 O_PIN_OE,
    output logic                            O_IRQ,
    output logic      [sbtc_pkg::CNT_W-1:0] O_COUNT,
    output logic                            O_TIMEBASE_OK
);

    // Control and status state
    sbtc_pkg::sbtc_ctrl_t ctrl_q;   // counter_control
    sbtc_pkg::sbtc_ctrl_t ctrl_d;
    logic                 ovf_q;    // overflow_flag
    logic                 ovf_d;
    logic                 ie_q;     // overflow_irq_enable
    logic                 ie_d;
    logic [sbtc_pkg::DATA_W-1:0] rdata_q; // Read data, one cycle late
    logic [sbtc_pkg::DATA_W-1:0] rdata_d;
    logic                 irq_q;    // Registered interrupt request
    logic                 irq_d;
    logic [1:0]           pin_o_q;  // Pin drive data
    logic [1:0]           pin_o_d;
    logic [1:0]           pin_oe_q; // Pin drive enables
    logic [1:0]           pin_oe_d;
    logic                 tb_ok_q;  // Time base offered to capture unit
    logic                 tb_ok_d;

    // Count state, deliberately without reset
    logic [sbtc_pkg::CNT_W-1:0] cnt_q;
    logic [sbtc_pkg::CNT_W-1:0] cnt_d;

    // Source path state
    logic [1:0]           qdiv_q;   // Instruction clock half-period counter
    logic [1:0]           qdiv_d;
    logic                 qlvl_q;   // Instruction clock as a level
    logic                 qlvl_d;
    logic                 src_q;    // Last source level
    logic                 src_d;

    // Combinational helpers
    logic                 wr_ctrl;
    logic                 wr_low;
    logic                 wr_high;
    logic                 wr_flags;
    logic                 src_lvl;  // Selected source level
    logic                 tick;     // Any edge of the source
    logic                 presc_lvl;
    logic                 inc;      // One-cycle increment strobe
    sbtc_pkg::sbtc_mode_t mode;

    // Pin filters: three stages, change taken when last two agree
    logic [1:0]           pin_raw;
    logic [1:0]           pin_flt_q;
    logic [1:0]           pin_flt_d;
    logic [sbtc_pkg::PIN_STAGES-1:0] pin_stg_q [2];

    assign pin_raw = {I_OSC_IN_PIN, I_EXT_COUNT_PIN};

    // One filter per pin
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_pin
            // Shift chain; stage 0 is read only by stage 1
            always_ff @(posedge I_MCLK or posedge I_RESET) begin
                if (I_RESET) begin
                    pin_stg_q[gp] <= '0;
                end else begin
                    pin_stg_q[gp] <= {pin_stg_q[gp][1:0], pin_raw[gp]};
                end
            end
            // Accept a change only when stages two and three agree
            always_comb begin
                pin_flt_d[gp] = pin_flt_q[gp];
                if (pin_stg_q[gp][1] == pin_stg_q[gp][2]) begin
                    pin_flt_d[gp] = pin_stg_q[gp][2];
                end
            end
        end
    endgenerate

    // Filtered pin levels
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            pin_flt_q <= 2'h0;
        end else begin
            pin_flt_q <= pin_flt_d;
        end
    end

    // Write decode
    assign wr_ctrl  = I_WR && (I_ADDR == sbtc_pkg::OFS_CTRL);
    assign wr_low   = I_WR && (I_ADDR == sbtc_pkg::OFS_CNT_LOW);
    assign wr_high  = I_WR && (I_ADDR == sbtc_pkg::OFS_CNT_HIGH);
    assign wr_flags = I_WR && (I_ADDR == sbtc_pkg::OFS_FLAGS);

    assign mode = sbtc_pkg::sbtc_mode(ctrl_q);

    // Source path: instruction clock level and source selection
    always_comb begin
        qdiv_d = qdiv_q;
        qlvl_d = qlvl_q;
        // Core clock stops in sleep, so the instruction clock does too
        if (!I_SLEEP) begin
            if (qdiv_q == 2'(sbtc_pkg::QCLK_HALF_CYC - 1)) begin
                qdiv_d = 2'h0;
                qlvl_d = ~qlvl_q;
            end else begin
                qdiv_d = qdiv_q + 2'h1;
            end
        end
        // Oscillator pin when enabled, else count pin [RULE9]
        if (ctrl_q.clk_sel) begin
            src_lvl = ctrl_q.osc_en ? pin_flt_q[1] : pin_flt_q[0];
        end else begin
            src_lvl = qlvl_q; // Internal clock [RULE4]
        end
        src_d = src_lvl;
        // Every source edge feeds the prescaler [RULE10]
        tick = src_lvl ^ src_q;
    end

    // Source path registers
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            qdiv_q <= 2'h0;
            qlvl_q <= 1'b0;
            src_q  <= 1'b0;
        end else begin
            qdiv_q <= qdiv_d;
            qlvl_q <= qlvl_d;
            src_q  <= src_d;
        end
    end

    // Prescaler runs in sleep and is cleared by count writes
    sbtc_prescaler #(
        .W       (sbtc_pkg::PRESC_W)
    ) u_presc (
        .i_clk   (I_MCLK),
        .i_rst   (I_RESET),
        .i_clear (wr_low | wr_high),   // [RULE23]
        .i_tick  (tick),               // [RULE11]
        .i_sel   (ctrl_q.prescale),    // [RULE6]
        .o_level (presc_lvl)
    );

    // Sampling after the prescaler; bypassed when unsynced or internal
    sbtc_edge_sync #(
        .STAGES   (sbtc_pkg::SYNC_STAGES)
    ) u_sync (
        .i_clk    (I_MCLK),
        .i_rst    (I_RESET),
        .i_level  (presc_lvl),
        .i_bypass (mode != sbtc_pkg::SBTC_SYNC_CNT),  // [RULE8] [RULE15]
        .i_enable (~I_SLEEP),                          // [RULE11]
        .o_strobe (inc)                                // [RULE14] [RULE28]
    );

    // Next values of registers, count and flag
    always_comb begin
        ctrl_d   = ctrl_q;
        ie_d     = ie_q;
        ovf_d    = ovf_q;
        cnt_d    = cnt_q;
        rdata_d  = sbtc_pkg::RDATA_RESET;
        // Control write; top two bits kept zero [RULE22]
        if (wr_ctrl) begin
            ctrl_d        = sbtc_pkg::sbtc_ctrl_t'(I_WDATA);
            ctrl_d.unused = 2'h0;
        end
        // Count: advance only while running [RULE5]
        if (inc && ctrl_q.run) begin
            cnt_d = cnt_q + 16'h0001; // Wraps past the top [RULE1]
            if (cnt_q == sbtc_pkg::COUNT_MAX) begin
                ovf_d = 1'b1; // [RULE2]
            end
        end
        // Trigger clear takes no flag with it [RULE21] [RULE24]
        if (I_CCP_CLEAR) begin
            cnt_d = '0;
            ovf_d = ovf_q; // A wrap cancelled by the clear leaves the flag alone
        end
        // Byte writes beat increment and trigger [RULE25]
        if (wr_low) begin
            cnt_d = {cnt_q[15:8], I_WDATA};
        end
        if (wr_high) begin
            cnt_d = {I_WDATA, cnt_q[7:0]};
        end
        // Flag cleared by writing zero; a same-cycle wrap wins [RULE27]
        if (wr_flags) begin
            ie_d = I_WDATA[sbtc_pkg::FLAG_IE_BIT];
            if (!I_WDATA[sbtc_pkg::FLAG_OVF_BIT]
                && !(inc && ctrl_q.run && cnt_q == sbtc_pkg::COUNT_MAX && !I_CCP_CLEAR)) begin
                ovf_d = 1'b0;
            end
        end
        // Reads come from core-domain flops only [RULE17]
        if (I_RD) begin
            case (I_ADDR)
                sbtc_pkg::OFS_CTRL:     rdata_d = ctrl_q;
                sbtc_pkg::OFS_CNT_LOW:  rdata_d = cnt_q[7:0];
                sbtc_pkg::OFS_CNT_HIGH: rdata_d = cnt_q[15:8];
                sbtc_pkg::OFS_FLAGS: begin
                    rdata_d = {6'h00, ie_q, ovf_q};
                end
                default:                rdata_d = sbtc_pkg::RDATA_RESET;
            endcase
        end
        // Request gated by enable, flag untouched [RULE3]
        irq_d = ovf_d & ie_d;
        // Oscillator enable forces both pins to input [RULE7]
        pin_oe_d = ctrl_d.osc_en ? 2'h0 : I_PIN_DIR_OUT;
        pin_o_d  = I_PIN_DATA;
        // Unsynced counting is no time base [RULE16]
        tb_ok_d = (sbtc_pkg::sbtc_mode(ctrl_d) != sbtc_pkg::SBTC_ASYNC_CNT);
    end

    // Control and status registers; reset to zero, except the time base flag, which resets to one [RULE26]
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            ctrl_q   <= sbtc_pkg::sbtc_ctrl_t'(sbtc_pkg::CTRL_RESET);
            ie_q     <= sbtc_pkg::FLAG_RESET;
            ovf_q    <= sbtc_pkg::FLAG_RESET;
            rdata_q  <= sbtc_pkg::RDATA_RESET;
            irq_q    <= 1'b0;
            pin_oe_q <= 2'h0;
            pin_o_q  <= 2'h0;
            tb_ok_q  <= 1'b1;
        end else begin
            ctrl_q   <= ctrl_d;
            ie_q     <= ie_d;
            ovf_q    <= ovf_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
            pin_oe_q <= pin_oe_d;
            pin_o_q  <= pin_o_d;
            tb_ok_q  <= tb_ok_d;
        end
    end

    // Count bytes survive every reset; only writes, trigger and increments change them [RULE26]
    always_ff @(posedge I_MCLK) begin
        cnt_q <= cnt_d;
    end

    // Outputs straight from flops
    assign O_RDATA       = rdata_q;
    assign O_IRQ         = irq_q;  // Wakes the core in unsynced mode [RULE15]
    assign O_COUNT       = cnt_q;
    assign O_TIMEBASE_OK = tb_ok_q;
    assign O_PIN_O       = pin_o_q;
    assign O_PIN_OE      = pin_oe_q;

endmodule : sbtc_top

// >>> sim/sbtc_props.sv
// Port checker of the 16-bit timer/counter.
// Assumes it is bound into sbtc_top and sees nothing but its ports.
`timescale 1ns/100ps
module sbtc_props (
    input wire logic                        I_MCLK,
    input wire logic                        I_RESET,
    input wire logic [sbtc_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [sbtc_pkg::DATA_W-1:0] I_WDATA,
    input wire logic                        I_WR,
    input wire logic                        I_RD,
    input wire logic [sbtc_pkg::DATA_W-1:0] O_RDATA,
    input wire logic                        I_SLEEP,
    input wire logic                        I_CCP_CLEAR,
    input wire logic                        I_OSC_IN_PIN,
    input wire logic                        I_EXT_COUNT_PIN,
    input wire logic [1:0]                  I_PIN_DIR_OUT,
    input wire logic [1:0]                  I_PIN_DATA,
    input wire logic [1:0]                  O_PIN_O,
    input wire logic [1:0]                  O_PIN_OE,
    input wire logic                        O_IRQ,
    input wire logic [sbtc_pkg::CNT_W-1:0]  O_COUNT,
    input wire logic                        O_TIMEBASE_OK
);
    sbtc_pkg::sbtc_ctrl_t ctrl_q, ctrl_d; // Shadow of the control register
    logic                 ie_q, ie_d;     // Shadow of the interrupt enable
    logic [2:0]           ev_q, ev_d;     // Recent count writes or clears
    logic                 known_q, known_d; // Count loaded since reset
    logic                 cnt_wr;         // Write to either count byte

    // Shadow next values; the count is X until loaded, so track that
    always_comb begin
        cnt_wr = I_WR && (I_ADDR == sbtc_pkg::OFS_CNT_LOW || I_ADDR == sbtc_pkg::OFS_CNT_HIGH);
        ctrl_d = ctrl_q;
        ie_d = ie_q;
        if (I_WR && I_ADDR == sbtc_pkg::OFS_CTRL) begin
            ctrl_d = sbtc_pkg::sbtc_ctrl_t'({2'h0, I_WDATA[5:0]});
        end
        if (I_WR && I_ADDR == sbtc_pkg::OFS_FLAGS) begin
            ie_d = I_WDATA[sbtc_pkg::FLAG_IE_BIT];
        end
        ev_d = {ev_q[1:0], cnt_wr || I_CCP_CLEAR};
        known_d = known_q || cnt_wr || I_CCP_CLEAR;
    end

    // Shadow registers
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            ctrl_q <= '0;
            ie_q <= 1'b0;
            ev_q <= 3'h0;
            known_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            ie_q <= ie_d;
            ev_q <= ev_d;
            known_q <= known_d;
        end
    end

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);

    rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data not zero outside read cycle");
    ctrl_read_a: assert property ($past(I_RD && I_ADDR == sbtc_pkg::OFS_CTRL) |->
        O_RDATA == $past(ctrl_q)) else $error("control readback wrong");
    ie_read_a: assert property ($past(I_RD && I_ADDR == sbtc_pkg::OFS_FLAGS) |->
        O_RDATA[1] == $past(ie_q)) else $error("enable readback wrong");
    irq_mask_a: assert property ((!ie_q && !$past(ie_q)) |-> !O_IRQ)
        else $error("interrupt while disabled");
    pin_dir_a: assert property (O_PIN_OE ==
        (ctrl_q.osc_en ? 2'h0 : $past(I_PIN_DIR_OUT))) else $error("pin enable wrong");
    time_base_a: assert property (O_TIMEBASE_OK ==
        !(ctrl_q.clk_sel && ctrl_q.sync_bypass)) else $error("time base flag wrong");
    count_hold_a: assert property ((known_q && !ctrl_q.run && ev_q == 3'h0)[*3] |->
        $stable(O_COUNT)) else $error("count moved while stopped");
    count_step_a: assert property ((known_q && ev_q == 3'h0 && $changed(O_COUNT)) |->
        O_COUNT == $past(O_COUNT) + 16'h0001) else $error("count step not one");
endmodule : sbtc_props

bind sbtc_top sbtc_props u_sbtc_props (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SLEEP(I_SLEEP),
    .I_CCP_CLEAR(I_CCP_CLEAR), .I_OSC_IN_PIN(I_OSC_IN_PIN), .I_EXT_COUNT_PIN(I_EXT_COUNT_PIN),
    .I_PIN_DIR_OUT(I_PIN_DIR_OUT), .I_PIN_DATA(I_PIN_DATA), .O_PIN_O(O_PIN_O),
    .O_PIN_OE(O_PIN_OE), .O_IRQ(O_IRQ), .O_COUNT(O_COUNT), .O_TIMEBASE_OK(O_TIMEBASE_OK));

// >>> sim/sbtc_clk_src.sv
// Model of the far side: an external count clock or a crystal source.
// Assumes the bench calls burst(); pins idle low between bursts.
`timescale 1ns/100ps
module sbtc_clk_src (
    output logic o_ext_pin, // Count pin level
    output logic o_osc_pin  // Oscillator input level
);
    // Source stands still until a burst is asked for
    initial begin
        o_ext_pin = 1'b0;
        o_osc_pin = 1'b0;
    end

    // Pulse train timed in ns, so its phase is free of the core clock
    task automatic burst(input logic osc, input int n, input int hi_ns, input int lo_ns);
        for (int i = 0; i < n; i++) begin
            if (osc) o_osc_pin = 1'b1;
            else o_ext_pin = 1'b1;
            #(hi_ns);
            if (osc) o_osc_pin = 1'b0;
            else o_ext_pin = 1'b0;
            #(lo_ns);
        end
    endtask : burst
endmodule : sbtc_clk_src

// >>> sim/sbtc_top_tb.sv
// Self-checking bench of the 16-bit timer/counter.
// Assumes sbtc_top, its bound checker and the clock source model.
`timescale 1ns/100ps
module sbtc_top_tb;
    logic        clk, rst, wr, rd, sleep, ccp_clr, irq, tb_ok, ext_src, osc_src;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata;
    logic [1:0]  dir, pdata, pin_o, pin_oe;
    logic [15:0] count;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc = 0;

    // Pin levels: design wins only where it enables its driver
    wire ext_pin = pin_oe[0] ? pin_o[0] : ext_src;
    wire osc_pin = pin_oe[1] ? pin_o[1] : osc_src;

    sbtc_top u_sbtc_top (.I_MCLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SLEEP(sleep), .I_CCP_CLEAR(ccp_clr),
        .I_OSC_IN_PIN(osc_pin), .I_EXT_COUNT_PIN(ext_pin), .I_PIN_DIR_OUT(dir),
        .I_PIN_DATA(pdata), .O_PIN_O(pin_o), .O_PIN_OE(pin_oe), .O_IRQ(irq),
        .O_COUNT(count), .O_TIMEBASE_OK(tb_ok));
    sbtc_clk_src u_sbtc_clk_src (.o_ext_pin(ext_src), .o_osc_pin(osc_src));

    // 25 MHz core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Hang guard, about five and a half times the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    // Compare, with a one-count slack where phase is unknown
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic tol);
        logic [15:0] d;
        d = got - exp;
        tests_run++;
        if (!(d === 16'h0000 || (tol && (d === 16'h0001 || d === 16'hFFFF)))) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write, optionally beside a trigger clear
    task automatic wrt(input logic [2:0] a, input logic [7:0] d, input logic clr = 1'b0);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        ccp_clr <= clr;
        @(posedge clk);
        wr <= 1'b0;
        ccp_clr <= 1'b0;
    endtask : wrt

    // One-cycle read; data looked at in the following cycle only
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, e}, 1'b0);
    endtask : rdc

    // Safe load order: low cleared, high, then low
    task automatic load(input logic [15:0] v);
        wrt(sbtc_pkg::OFS_CNT_LOW, 8'h00);
        wrt(sbtc_pkg::OFS_CNT_HIGH, v[15:8]);
        wrt(sbtc_pkg::OFS_CNT_LOW, v[7:0]);
    endtask : load

    // Run from zero for some cycles or pulses, stop, compare the count
    task automatic go(input logic [7:0] c, input int cy, input logic osc, input int n,
                      input logic [15:0] e);
        wrt(sbtc_pkg::OFS_CTRL, c & 8'hFE);
        load(16'h0000);
        wrt(sbtc_pkg::OFS_CTRL, c);
        if (n > 0) begin
            u_sbtc_clk_src.burst(osc, n, 130, 130);
            repeat (30) @(posedge clk);
        end else begin
            repeat (cy) @(posedge clk);
        end
        wrt(sbtc_pkg::OFS_CTRL, c & 8'hFE);
        repeat (4) @(posedge clk);
        chk(count, e, n == 0);
    endtask : go

    // Report and end; the only exit of the run
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        {rst, wr, rd, sleep, ccp_clr} = 5'h10;
        {addr, wdata, dir, pdata} = 15'h0000;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(sbtc_pkg::OFS_CTRL, 8'h00);
        rdc(sbtc_pkg::OFS_FLAGS, 8'h00);
        wrt(sbtc_pkg::OFS_CTRL, 8'hFE);
        rdc(sbtc_pkg::OFS_CTRL, 8'h3E);
        chk({15'h0000, tb_ok}, 16'h0000, 1'b0);
        rdc(3'h5, 8'h00);
        wrt(sbtc_pkg::OFS_CTRL, 8'h30);
        load(16'h1234);
        rdc(sbtc_pkg::OFS_CNT_HIGH, 8'h12);
        rdc(sbtc_pkg::OFS_CNT_LOW, 8'h34);
        rdc(sbtc_pkg::OFS_CNT_HIGH, 8'h12);
        repeat (50) @(posedge clk);
        chk(count, 16'h1234, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk(count, 16'h1234, 1'b0);
        rdc(sbtc_pkg::OFS_CTRL, 8'h00);
        for (int p = 0; p < 4; p++) begin
            go({2'h0, 2'(p), 4'h1}, 512, 1'b0, 0, 16'h0080 >> p);
        end
        go(8'h05, 512, 1'b0, 0, 16'h0080);
        go(8'h03, 0, 1'b0, 10, 16'h000A);
        go(8'h23, 0, 1'b0, 16, 16'h0004);
        u_sbtc_clk_src.burst(1'b0, 3, 130, 130);
        go(8'h23, 0, 1'b0, 2, 16'h0001);
        {dir, pdata} <= 4'hE;
        repeat (2) @(posedge clk);
        chk({12'h000, pin_oe, pin_o}, 16'h000E, 1'b0);
        go(8'h0B, 0, 1'b0, 6, 16'h0000);
        go(8'h0B, 0, 1'b1, 6, 16'h0006);
        chk({12'h000, pin_oe, pin_o}, 16'h0002, 1'b0);
        dir <= 2'h0;
        sleep <= 1'b1;
        go(8'h03, 0, 1'b0, 6, 16'h0000);
        go(8'h07, 0, 1'b0, 6, 16'h0006);
        sleep <= 1'b0;
        wrt(sbtc_pkg::OFS_FLAGS, 8'h02);
        load(16'hFFF0);
        wrt(sbtc_pkg::OFS_CTRL, 8'h01);
        repeat (100) @(posedge clk);
        wrt(sbtc_pkg::OFS_CTRL, 8'h00);
        rdc(sbtc_pkg::OFS_FLAGS, 8'h03);
        chk({15'h0000, irq}, 16'h0001, 1'b0);
        wrt(sbtc_pkg::OFS_FLAGS, 8'h01);
        rdc(sbtc_pkg::OFS_FLAGS, 8'h01);
        chk({15'h0000, irq}, 16'h0000, 1'b0);
        wrt(sbtc_pkg::OFS_FLAGS, 8'h02);
        rdc(sbtc_pkg::OFS_FLAGS, 8'h02);
        chk({15'h0000, irq}, 16'h0000, 1'b0);
        load(16'h5A5A);
        @(posedge clk);
        ccp_clr <= 1'b1;
        @(posedge clk);
        ccp_clr <= 1'b0;
        repeat (3) @(posedge clk);
        chk(count, 16'h0000, 1'b0);
        rdc(sbtc_pkg::OFS_FLAGS, 8'h02);
        load(16'h1234);
        wrt(sbtc_pkg::OFS_CNT_LOW, 8'h77, 1'b1);
        rdc(sbtc_pkg::OFS_CNT_LOW, 8'h77);
        close_out();
    end
endmodule : sbtc_top_tb
